/* core/turo_pkg.sv */
// How it works
// - Capture register in compare mode ignores its trigger pin for interrupts.
// - External clear of timer two enabled blocks its output channel.
// - Up/down mode 4 counts every edge; edge selection has no effect.
// - External clock on timer zero or one blocks its timer output channel; shared output B, fed by timer one, stays unblocked.
// - Disabled shared outputs turn their pins into external interrupt inputs.
// - Timer one, two and up/down wrap flags clear only by software.
// - Timer zero and three wrap flags are read-only; interrupt clear clears them.
// - Interval compare above zero: first match after value, later value plus one.
// - Timer three with compare zero matches on every count clock.
// - Enabled shared output level change sets its pin request flag bit 7.
// - Real-time buffer bits not connected to a pin read as zero.
// - Software trigger drives both real-time buffers to the pins.
package turo_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_OUTCTL = 12'h004;
    localparam logic [11:0] ADDR_CMP0 = 12'h008;
    localparam logic [11:0] ADDR_CMP1 = 12'h00C;
    localparam logic [11:0] ADDR_CMP2 = 12'h010;
    localparam logic [11:0] ADDR_CCMODE = 12'h014;
    localparam logic [11:0] ADDR_CAPCOMP_ZERO_ZERO = 12'h018;
    localparam logic [11:0] ADDR_CAPCOMP_THREE_ZERO = 12'h01C;
    localparam logic [11:0] ADDR_WRAPST = 12'h020;
    localparam logic [11:0] ADDR_IRQST = 12'h024;
    localparam logic [11:0] ADDR_IRQMASK = 12'h028;
    localparam logic [11:0] ADDR_PINIRQ = 12'h02C;
    localparam logic [11:0] ADDR_RTLOW = 12'h030;
    localparam logic [11:0] ADDR_RTHIGH = 12'h034;
    localparam logic [11:0] ADDR_RTMODE = 12'h038;
    localparam logic [11:0] ADDR_UDCNT = 12'h03C;
    localparam logic [11:0] ADDR_CNT0 = 12'h040;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Control register fields.
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_T0_EXT = 4;
    localparam int CTRL_T1_EXT = 5;
    localparam int CTRL_T2_XCLR = 6;
    localparam int CTRL_UD_RUN = 7;
    localparam int CTRL_UD_MODE_LSB = 8;
    localparam int CTRL_UD_EDGE_LSB = 11;
    localparam int CTRL_UD_DOWN = 13;
    localparam int CTRL_IVL_LSB = 16;
    localparam logic [2:0] UD_MODE_PIN_DIR = 3'h4;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    // Output control: enables in low byte, active levels in high byte.
    localparam int OUT_EN_LSB = 0;
    localparam int OUT_ALV_LSB = 8;
    localparam int NOUT = 5;
    localparam int O_T0C3 = 0;
    localparam int O_T1C1 = 1;
    localparam int O_T2C1 = 2;
    localparam int O_SHA = 3;
    localparam int O_SHB = 4;
    // Wrap status bits.
    localparam int WR_T0 = 0;
    localparam int WR_T3 = 3;
    localparam int WR_UP = 4;
    localparam int WR_DOWN = 5;
    localparam logic [5:0] WRAP_SW_CLR = 6'h36;
    // Interrupt status bits.
    localparam int IRQ_T0WRAP = 0;
    localparam int IRQ_T3WRAP = 1;
    localparam int IRQ_CAP0 = 2;
    localparam int IRQ_CAP3 = 3;
    localparam int IRQ_MATCH_LSB = 4;
    // Pin interrupt control: flag at bit 7, mask at bit 6, per byte.
    localparam int PIN_A_FLAG = 7;
    localparam int PIN_A_MASK = 6;
    localparam int PIN_B_FLAG = 15;
    localparam int PIN_B_MASK = 14;
    localparam logic [15:0] PIN_BITS = 16'hC0C0;
    // Real-time port mode: pin connect mask and trigger select.
    localparam int RT_TRIG_LSB = 8;
    localparam logic [1:0] TRIG_SW = 2'h1;
    localparam logic [1:0] TRIG_T0 = 2'h2;
    // Synchroniser lanes.
    localparam int SI_T0CLK = 0;
    localparam int SI_T1CLK = 1;
    localparam int SI_T2CLR = 2;
    localparam int SI_UDIN = 3;
    localparam int SI_UDDIR = 4;
    localparam int SI_CAP0 = 5;
    localparam int SI_CAP3 = 6;
    localparam int SI_PINA = 7;
    localparam int SI_PINB = 8;
    localparam int SYNC_W = 9;
endpackage

/* core/turo_tmr_if.sv */
`timescale 1ns/10ps
interface turo_tmr_if;
    logic run;
    logic tick;
    logic clr;
    logic interval;
    logic [15:0] cmp;
    logic [15:0] count;
    logic match;
    logic wrap;
    modport ctl(output run, tick, clr, interval, cmp, input count, match, wrap);
    modport tmr(input run, tick, clr, interval, cmp, output count, match, wrap);
endinterface

/* core/turo_sync.sv */
`timescale 1ns/10ps
module turo_sync #(parameter int W = 1) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* core/turo_timer.sv */
`timescale 1ns/10ps
module turo_timer (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control and events.
    turo_tmr_if.tmr t
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic hit;
    logic adv;

    // A hit clears the count on the next tick, which is why later
    // intervals are one count clock longer than the first.
    assign hit = t.interval && (cnt_r == t.cmp);
    assign adv = t.run && t.tick && !t.clr;

    always_comb begin
        cnt_nxt = cnt_r;
        if (!t.run || t.clr) begin
            cnt_nxt = 16'h0000;
        end else if (t.tick) begin
            cnt_nxt = hit ? 16'h0000 : cnt_r + 16'h0001;
        end
    end

    assign t.match = adv && t.interval && (cnt_nxt == t.cmp);
    assign t.wrap = adv && !hit && (cnt_r == 16'hFFFF);
    assign t.count = cnt_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* core/turo_top.sv */
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module turo_top import turo_pkg::*; (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Input pins.
    input wire logic timer0_ext_clock,
    input wire logic timer1_ext_clock,
    input wire logic timer2_clear_input,
    input wire logic updown_count_input,
    input wire logic updown_dir_input,
    input wire logic capture0_trigger,
    input wire logic capture3_trigger,
    // Timer output pins.
    output logic timer0_output_ch3,
    output logic timer1_output_ch1,
    output logic timer2_output_ch1,
    // Shared output or interrupt pins.
    input wire logic shared_a_in,
    output logic shared_a_out,
    output logic shared_a_oe,
    input wire logic shared_b_in,
    output logic shared_b_out,
    output logic shared_b_oe,
    // Real-time port and interrupt.
    output logic [7:0] rt_port_out,
    output logic irq
);
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [15:0] outctl_r, outctl_nxt;
    logic [15:0] cmp_r [3];
    logic [15:0] cmp_nxt [3];
    logic [1:0] ccm_r, ccm_nxt;
    logic [15:0] capcomp_zero_zero_r, capcomp_zero_zero_nxt, capcomp_three_zero_r, capcomp_three_zero_nxt;
    logic [5:0] wrap_r, wrap_nxt;
    logic [7:0] irqs_r, irqs_nxt, irqm_r, irqm_nxt;
    logic [15:0] pin_r, pin_nxt;
    logic [3:0] rtl_r, rtl_nxt, rth_r, rth_nxt;
    logic [9:0] rtm_r, rtm_nxt;
    logic [15:0] ud_r, ud_nxt;
    logic [NOUT-1:0] tog_r, tog_nxt, pout_r, pout_nxt;
    logic [7:0] rtout_r, rtout_nxt;
    logic [SYNC_W-1:0] s_q, s_prev_r, rise, fall;
    logic [31:0] prdata_r, prdata_nxt, rd_data;
    logic slverr_r, slverr_nxt, rd_hit;
    logic wr_acc, rd_acc, ud_step, ud_down;
    logic [2:0] ud_mode;
    logic [1:0] ud_edge, rt_trig;
    logic [NOUT-1:0] out_en, alv, eff_en, src;
    logic [3:0] run_v, tick_v, clr_v, ivl_v, match_v, wrap_v;
    logic [15:0] cmpv [4];
    logic [15:0] cnt_v [4];

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = slverr_r;

    turo_sync #(.W(SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({shared_b_in, shared_a_in, capture3_trigger, capture0_trigger,
            updown_dir_input, updown_count_input, timer2_clear_input,
            timer1_ext_clock, timer0_ext_clock}),
        .q(s_q)
    );
    assign rise = s_q & ~s_prev_r;
    assign fall = ~s_q & s_prev_r;

    // Timers: zero and one may count pin edges, timer two may be
    // cleared from its pin, timer three compares against its capcomp.
    assign run_v = ctrl_r[CTRL_RUN_LSB +: 4];
    assign ivl_v = ctrl_r[CTRL_IVL_LSB +: 4] & {!ccm_r[1], 3'b111};
    assign tick_v = {2'b11, ctrl_r[CTRL_T1_EXT] ? rise[SI_T1CLK] : 1'b1,
                     ctrl_r[CTRL_T0_EXT] ? rise[SI_T0CLK] : 1'b1};
    assign clr_v = {1'b0, ctrl_r[CTRL_T2_XCLR] && rise[SI_T2CLR], 2'b00};
    assign cmpv[0] = cmp_r[0];
    assign cmpv[1] = cmp_r[1];
    assign cmpv[2] = cmp_r[2];
    assign cmpv[3] = capcomp_three_zero_r;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tmr
            turo_tmr_if tif ();
            assign tif.run = run_v[gi];
            assign tif.tick = tick_v[gi];
            assign tif.clr = clr_v[gi];
            assign tif.interval = ivl_v[gi];
            assign tif.cmp = cmpv[gi];
            assign match_v[gi] = tif.match;
            assign wrap_v[gi] = tif.wrap;
            assign cnt_v[gi] = tif.count;
            turo_timer u_tmr (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .t(tif.tmr)
            );
        end
    endgenerate

    assign out_en = outctl_r[OUT_EN_LSB +: NOUT];
    assign alv = outctl_r[OUT_ALV_LSB +: NOUT];
    assign eff_en = out_en & ~{2'b00, ctrl_r[CTRL_T2_XCLR],
                               ctrl_r[CTRL_T1_EXT], ctrl_r[CTRL_T0_EXT]};
    assign src = {match_v[1], match_v[3], match_v[2], match_v[1], match_v[0]};
    assign ud_mode = ctrl_r[CTRL_UD_MODE_LSB +: 3];
    assign ud_edge = ctrl_r[CTRL_UD_EDGE_LSB +: 2];
    assign rt_trig = rtm_r[RT_TRIG_LSB +: 2];

    always_comb begin
        if (ud_mode == UD_MODE_PIN_DIR) begin
            ud_step = rise[SI_UDIN] || fall[SI_UDIN];
            ud_down = s_q[SI_UDDIR];
        end else begin
            ud_step = (ud_edge == EDGE_RISE) ? rise[SI_UDIN] :
                      (ud_edge == EDGE_FALL) ? fall[SI_UDIN] :
                      (rise[SI_UDIN] || fall[SI_UDIN]);
            ud_down = ctrl_r[CTRL_UD_DOWN];
        end
    end

    // Software effects come first so that any hardware set below wins.
    always_comb begin
        ctrl_nxt = ctrl_r;
        outctl_nxt = outctl_r;
        cmp_nxt = cmp_r;
        ccm_nxt = ccm_r;
        capcomp_zero_zero_nxt = capcomp_zero_zero_r;
        capcomp_three_zero_nxt = capcomp_three_zero_r;
        wrap_nxt = wrap_r;
        irqs_nxt = irqs_r;
        irqm_nxt = irqm_r;
        pin_nxt = pin_r;
        rtl_nxt = rtl_r;
        rth_nxt = rth_r;
        rtm_nxt = rtm_r;
        ud_nxt = ud_r;
        tog_nxt = tog_r;
        rtout_nxt = rtout_r;
        if (wr_acc) begin
            case (paddr)
                ADDR_CTRL: ctrl_nxt = pwdata;
                ADDR_OUTCTL: outctl_nxt = pwdata[15:0];
                ADDR_CMP0: cmp_nxt[0] = pwdata[15:0];
                ADDR_CMP1: cmp_nxt[1] = pwdata[15:0];
                ADDR_CMP2: cmp_nxt[2] = pwdata[15:0];
                ADDR_CCMODE: ccm_nxt = pwdata[1:0];
                ADDR_CAPCOMP_ZERO_ZERO: capcomp_zero_zero_nxt = pwdata[15:0];
                ADDR_CAPCOMP_THREE_ZERO: capcomp_three_zero_nxt = pwdata[15:0];
                ADDR_WRAPST: wrap_nxt = wrap_r & ~(pwdata[5:0] & WRAP_SW_CLR);
                ADDR_IRQMASK: irqm_nxt = pwdata[7:0];
                ADDR_PINIRQ: pin_nxt = pwdata[15:0] & PIN_BITS;
                ADDR_RTLOW: rtl_nxt = pwdata[3:0];
                ADDR_RTHIGH: rth_nxt = pwdata[3:0];
                ADDR_RTMODE: rtm_nxt = pwdata[9:0];
                ADDR_UDCNT: ud_nxt = pwdata[15:0];
                default: ;
            endcase
        end
        // Only the bits that the read returned are cleared.
        if (rd_acc && paddr == ADDR_IRQST) begin
            irqs_nxt = irqs_r & ~prdata_r[7:0];
            if (prdata_r[IRQ_T0WRAP]) begin
                wrap_nxt[WR_T0] = 1'b0;
            end
            if (prdata_r[IRQ_T3WRAP]) begin
                wrap_nxt[WR_T3] = 1'b0;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (wrap_v[i]) begin
                wrap_nxt[i] = 1'b1;
            end
            if (match_v[i]) begin
                irqs_nxt[IRQ_MATCH_LSB + i] = 1'b1;
            end
        end
        if (wrap_v[0]) begin
            irqs_nxt[IRQ_T0WRAP] = 1'b1;
        end
        if (wrap_v[3]) begin
            irqs_nxt[IRQ_T3WRAP] = 1'b1;
        end
        // Compare mode leaves the trigger pin without effect.
        if (ccm_r[0] && rise[SI_CAP0]) begin
            capcomp_zero_zero_nxt = cnt_v[0];
            irqs_nxt[IRQ_CAP0] = 1'b1;
        end
        if (ccm_r[1] && rise[SI_CAP3]) begin
            capcomp_three_zero_nxt = cnt_v[3];
            irqs_nxt[IRQ_CAP3] = 1'b1;
        end
        if (ctrl_r[CTRL_UD_RUN] && ud_step) begin
            if (ud_down) begin
                ud_nxt = ud_r - 16'h0001;
                if (ud_r == 16'h0000) begin
                    wrap_nxt[WR_DOWN] = 1'b1;
                end
            end else begin
                ud_nxt = ud_r + 16'h0001;
                if (ud_r == 16'hFFFF) begin
                    wrap_nxt[WR_UP] = 1'b1;
                end
            end
        end
        for (int i = 0; i < NOUT; i++) begin
            if (!eff_en[i]) begin
                tog_nxt[i] = 1'b0;
            end else if (src[i]) begin
                tog_nxt[i] = ~tog_r[i];
            end
        end
        if (eff_en[O_SHA] ? src[O_SHA] : rise[SI_PINA]) begin
            pin_nxt[PIN_A_FLAG] = 1'b1;
        end
        if (eff_en[O_SHB] ? src[O_SHB] : rise[SI_PINB]) begin
            pin_nxt[PIN_B_FLAG] = 1'b1;
        end
        if (rt_trig == TRIG_SW || (rt_trig == TRIG_T0 && match_v[0])) begin
            rtout_nxt = {rth_r, rtl_r};
        end
        rtout_nxt = rtout_nxt & rtm_r[7:0];
        pout_nxt = eff_en & (tog_nxt ^ ~alv);
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_data = RST_WORD;
        case (paddr)
            ADDR_CTRL: rd_data = ctrl_r;
            ADDR_OUTCTL: rd_data = {16'h0000, outctl_r};
            ADDR_CMP0: rd_data = {16'h0000, cmp_r[0]};
            ADDR_CMP1: rd_data = {16'h0000, cmp_r[1]};
            ADDR_CMP2: rd_data = {16'h0000, cmp_r[2]};
            ADDR_CCMODE: rd_data = {30'h0000_0000, ccm_r};
            ADDR_CAPCOMP_ZERO_ZERO: rd_data = {16'h0000, capcomp_zero_zero_r};
            ADDR_CAPCOMP_THREE_ZERO: rd_data = {16'h0000, capcomp_three_zero_r};
            ADDR_WRAPST: rd_data = {26'h000_0000, wrap_r};
            ADDR_IRQST: rd_data = {24'h00_0000, irqs_r};
            ADDR_IRQMASK: rd_data = {24'h00_0000, irqm_r};
            ADDR_PINIRQ: rd_data = {16'h0000, pin_r};
            ADDR_RTLOW: rd_data = {28'h000_0000, rtl_r & rtm_r[3:0]};
            ADDR_RTHIGH: rd_data = {28'h000_0000, rth_r & rtm_r[7:4]};
            ADDR_RTMODE: rd_data = {22'h00_0000, rtm_r};
            ADDR_UDCNT: rd_data = {16'h0000, ud_r};
            ADDR_CNT0: rd_data = {16'h0000, cnt_v[0]};
            default: rd_hit = 1'b0;
        endcase
        prdata_nxt = prdata_r;
        slverr_nxt = slverr_r;
        if (psel && !penable) begin
            prdata_nxt = pwrite ? RST_WORD : rd_data;
            slverr_nxt = !rd_hit;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= RST_WORD;
            outctl_r <= 16'h0000;
            cmp_r <= '{default: 16'h0000};
            ccm_r <= 2'b00;
            capcomp_zero_zero_r <= 16'h0000;
            capcomp_three_zero_r <= 16'h0000;
            wrap_r <= 6'h00;
            irqs_r <= 8'h00;
            irqm_r <= 8'h00;
            pin_r <= 16'h0000;
            rtl_r <= 4'h0;
            rth_r <= 4'h0;
            rtm_r <= 10'h000;
            ud_r <= 16'h0000;
            tog_r <= '0;
            pout_r <= '0;
            rtout_r <= 8'h00;
            s_prev_r <= '0;
            prdata_r <= RST_WORD;
            slverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            outctl_r <= outctl_nxt;
            cmp_r <= cmp_nxt;
            ccm_r <= ccm_nxt;
            capcomp_zero_zero_r <= capcomp_zero_zero_nxt;
            capcomp_three_zero_r <= capcomp_three_zero_nxt;
            wrap_r <= wrap_nxt;
            irqs_r <= irqs_nxt;
            irqm_r <= irqm_nxt;
            pin_r <= pin_nxt;
            rtl_r <= rtl_nxt;
            rth_r <= rth_nxt;
            rtm_r <= rtm_nxt;
            ud_r <= ud_nxt;
            tog_r <= tog_nxt;
            pout_r <= pout_nxt;
            rtout_r <= rtout_nxt;
            s_prev_r <= s_q;
            prdata_r <= prdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    assign timer0_output_ch3 = pout_r[O_T0C3];
    assign timer1_output_ch1 = pout_r[O_T1C1];
    assign timer2_output_ch1 = pout_r[O_T2C1];
    assign shared_a_out = pout_r[O_SHA];
    assign shared_a_oe = eff_en[O_SHA];
    assign shared_b_out = pout_r[O_SHB];
    assign shared_b_oe = eff_en[O_SHB];
    assign rt_port_out = rtout_r;
    assign irq = |(irqs_r & irqm_r) ||
                 (pin_r[PIN_A_FLAG] && !pin_r[PIN_A_MASK]) ||
                 (pin_r[PIN_B_FLAG] && !pin_r[PIN_B_MASK]);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_sha_level_change;
        eff_en[O_SHA] && src[O_SHA];
    endsequence
    sequence s_sha_flag_up;
        pin_r[PIN_A_FLAG] && (shared_a_out != $past(shared_a_out));
    endsequence

    a_capture_cmp_quiet: assert property (
        !ccm_r[0] && !irqs_r[IRQ_CAP0] |=> !irqs_r[IRQ_CAP0])
        else $error("capture interrupt raised in compare mode");
    a_t2_out_blocked: assert property (
        ctrl_r[CTRL_T2_XCLR] |=> !timer2_output_ch1)
        else $error("timer two output active with external clear");
    a_ud_mode4_step: assert property (
        ctrl_r[CTRL_UD_RUN] && ud_mode == UD_MODE_PIN_DIR && fall[SI_UDIN]
        |=> ud_r != $past(ud_r))
        else $error("mode 4 missed a count edge");
    a_t0_ext_block: assert property (
        ctrl_r[CTRL_T0_EXT] |=> !timer0_output_ch3)
        else $error("timer zero channel 3 active with external clock");
    a_shared_irq_pin: assert property (
        !shared_a_oe && rise[SI_PINA] |=> pin_r[PIN_A_FLAG])
        else $error("shared pin edge did not raise request");
    a_sw_flag_hold: assert property (
        wrap_r[1] && !(wr_acc && paddr == ADDR_WRAPST) |=> wrap_r[1])
        else $error("timer one wrap flag cleared by hardware");
    a_t0_flag_ack: assert property (
        rd_acc && paddr == ADDR_IRQST && prdata_r[IRQ_T0WRAP] && !wrap_v[0]
        |=> !wrap_r[WR_T0])
        else $error("timer zero wrap flag survived acknowledge");
    a_t3_zero_every: assert property (
        run_v[3] && ivl_v[3] && capcomp_three_zero_r == 16'h0000 |-> match_v[3])
        else $error("timer three missed a match at compare zero");
    a_sha_change_flag: assert property (
        s_sha_level_change |=> s_sha_flag_up)
        else $error("shared output change did not set request flag");
    a_rt_read_mask: assert property (
        psel && !penable && !pwrite && paddr == ADDR_RTLOW
        |=> (prdata_r[3:0] & ~rtm_r[3:0]) == 4'h0)
        else $error("unconnected real-time bits read non-zero");
    a_rt_sw_drive: assert property (
        rt_trig == TRIG_SW
        |=> rt_port_out == ({$past(rth_r), $past(rtl_r)} & 8'($past(rtm_r))))
        else $error("software trigger did not drive buffers");
    a_t1_wrap_set: assert property (
        wrap_v[1] |=> wrap_r[1])
        else $error("timer one wrap not flagged");
    a_reset_idle: assert property (@(posedge clk_sys) disable iff (1'b0)
        sys_rst |=> ctrl_r == RST_WORD && wrap_r == 6'h00 && pout_r == '0)
        else $error("unit not idle after reset");
endmodule

/* tb/turo_pins.sv */
`timescale 1ns/10ps
// Far-side pins: each level is launched one clock after the bench asks for it.
module turo_pins (
    // Clock.
    input wire logic clk_sys,
    // Requested and driven pin levels.
    input wire logic [7:0] req,
    output logic [7:0] pin
);
    // Pins follow the requested levels on every clock, whether or not the timer they feed is running.
    always_ff @(posedge clk_sys) begin
        pin <= req;
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top import turo_pkg::*;;
    typedef struct packed {logic [11:0] a; logic [31:0] d;} turo_row_t;
    logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, err, t03, t11, t21, sao, saoe, sbo, sboe, irq, acc;
    logic [7:0] req = 8'h00, pin, rt_port_out;
    int n_fail = 0, total_checks = 0, n;
    wire sai = saoe ? sao : pin[6];
    wire sbi = sboe ? sbo : pin[7];
    wire [2:0] outs = {sao, t21, t03};
    turo_row_t rows[7] = '{'{ADDR_CTRL, RST_WORD}, '{ADDR_OUTCTL, RST_WORD},
        '{ADDR_WRAPST, RST_WORD}, '{ADDR_IRQST, RST_WORD}, '{ADDR_PINIRQ, RST_WORD},
        '{ADDR_RTMODE, RST_WORD}, '{ADDR_CNT0, RST_WORD}};
    turo_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_ext_clock(pin[0]), .timer1_ext_clock(pin[1]),
        .timer2_clear_input(pin[2]), .updown_count_input(pin[3]), .updown_dir_input(1'b0),
        .capture0_trigger(pin[4]), .capture3_trigger(pin[5]), .timer0_output_ch3(t03),
        .timer1_output_ch1(t11), .timer2_output_ch1(t21), .shared_a_in(sai),
        .shared_a_out(sao), .shared_a_oe(saoe), .shared_b_in(sbi), .shared_b_out(sbo),
        .shared_b_oe(sboe), .rt_port_out(rt_port_out), .irq(irq));
    turo_pins pins_u (.clk_sys(clk_sys), .req(req), .pin(pin));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task pulse(input int i);
        req[i] <= 1;
        repeat (5) @(posedge clk_sys);
        req[i] <= 0;
        repeat (5) @(posedge clk_sys);
    endtask
    task gap(input int s, output int c);
        logic v;
        v = outs[s];
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (outs[s] === v && c < 100);
    endtask
    initial begin
        #300000;
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 0;
        @(posedge clk_sys);
        chk({irq, sboe, saoe, t21, t11, t03, rt_port_out}, 0);
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            chk(q, rows[i].d);
        end
        apb(0, 12'h0FC, 0);
        chk(err, 1'b1);
        chk(q, 32'h0000_0000);
        $display("reset done");
        apb(1, ADDR_CMP0, 3);
        apb(1, ADDR_OUTCTL, 32'h0000_0909);
        apb(1, ADDR_CTRL, 32'h0009_0009);
        gap(0, n);
        gap(0, n);
        chk(n, 4);
        gap(0, n);
        chk(n, 4);
        gap(2, n);
        gap(2, n);
        chk(n, 1);
        apb(0, ADDR_PINIRQ, 0);
        chk(q & 32'h80, 32'h80);
        $display("interval done");
        apb(1, ADDR_CTRL, 0);
        apb(1, ADDR_CMP2, 1);
        apb(1, ADDR_OUTCTL, 0);
        apb(1, ADDR_OUTCTL, 32'h0000_0505);
        apb(1, ADDR_CTRL, 32'h0005_0055);
        acc = 0;
        // Look at both blocked outputs on every clock, not once per pulse.
        for (int i = 0; i < 40; i++) begin
            req[0] <= (i % 10 < 5);
            @(posedge clk_sys);
            acc = acc | t03 | t21;
        end
        req[0] <= 0;
        chk(acc, 0);
        apb(1, ADDR_CTRL, 0);
        apb(1, ADDR_OUTCTL, 0);
        apb(1, ADDR_IRQMASK, 0);
        apb(0, ADDR_IRQST, 0);
        apb(1, ADDR_PINIRQ, 0);
        chk(saoe, 0);
        pulse(6);
        apb(0, ADDR_PINIRQ, 0);
        chk({q[7], irq}, 2'b11);
        apb(1, ADDR_PINIRQ, 0);
        apb(1, ADDR_CCMODE, 0);
        pulse(4);
        apb(0, ADDR_IRQST, 0);
        chk(q & 32'h4, 0);
        apb(1, ADDR_CCMODE, 1);
        pulse(4);
        apb(0, ADDR_IRQST, 0);
        chk(q & 32'h4, 32'h4);
        $display("pins done");
        apb(1, ADDR_UDCNT, 32'h0000_FFFF);
        apb(1, ADDR_CTRL, 32'h0000_0080);
        pulse(3);
        apb(0, ADDR_WRAPST, 0);
        apb(0, ADDR_WRAPST, 0);
        chk(q & 32'h10, 32'h10);
        apb(1, ADDR_WRAPST, 32'h0000_0010);
        apb(0, ADDR_WRAPST, 0);
        chk(q & 32'h10, 0);
        apb(1, ADDR_CTRL, 0);
        apb(1, ADDR_UDCNT, 0);
        apb(1, ADDR_CTRL, 32'h0000_0C80);
        pulse(3);
        apb(0, ADDR_UDCNT, 0);
        chk(q, 2);
        $display("updown done");
        apb(1, ADDR_RTMODE, 32'h0000_000F);
        apb(1, ADDR_RTLOW, 32'h0000_000A);
        apb(1, ADDR_RTHIGH, 32'h0000_0005);
        apb(0, ADDR_RTHIGH, 0);
        chk(q, 0);
        apb(1, ADDR_RTMODE, 32'h0000_01FF);
        repeat (3) @(posedge clk_sys);
        chk(rt_port_out, 8'h5A);
        $display("realtime done");
        stop_test;
    end
endmodule
